// [inc/nvm_regs_pkg.sv]
package nvm_regs_pkg;

   // Register byte addresses on the bus
   localparam logic [7:0] OFS_DATA_LOW     = 8'h00;
   localparam logic [7:0] OFS_DATA_HIGH    = 8'h04;
   localparam logic [7:0] OFS_ADDRESS_LOW  = 8'h08;
   localparam logic [7:0] OFS_ADDRESS_HIGH = 8'h0C;
   localparam logic [7:0] OFS_CONTROL_ONE  = 8'h10;
   localparam logic [7:0] OFS_UNLOCK_PORT  = 8'h14;

   // Field widths
   localparam int DATA_LOW_W  = 8;
   localparam int DATA_HIGH_W = 6;
   localparam int ADDR_LOW_W  = 8;
   localparam int ADDR_HIGH_W = 7;
   localparam int WORD_W      = DATA_LOW_W + DATA_HIGH_W;
   localparam int ADDR_W      = ADDR_LOW_W + ADDR_HIGH_W;

   // Control register bit positions
   localparam int BIT_PROGRAM_SPACE = 7;
   localparam int BIT_CONFIG_SPACE  = 6;
   localparam int BIT_LATCH_ONLY    = 5;
   localparam int BIT_ERASE_SELECT  = 4;
   localparam int BIT_WRITE_ERROR   = 3;
   localparam int BIT_WRITE_ENABLE  = 2;
   localparam int BIT_WRITE_STROBE  = 1;
   localparam int BIT_READ_STROBE   = 0;

   // Reset values
   localparam logic [7:0] RST_ADDRESS_LOW  = 8'h00;
   localparam logic [6:0] RST_ADDRESS_HIGH = 7'h00;
   localparam logic [7:0] RST_CONTROL_ONE  = 8'h00;
   localparam logic [1:0] DATA_HIGH_PAD    = 2'h0;
   localparam logic       ADDR_HIGH_PAD    = 1'b1;

   // Readable configuration-space word offsets
   localparam logic [ADDR_W-1:0] CFG_USER_ID_LAST = 15'h0003;
   localparam logic [ADDR_W-1:0] CFG_DEVICE_ID    = 15'h0006;
   localparam logic [ADDR_W-1:0] CFG_WORD_FIRST   = 15'h0007;
   localparam logic [ADDR_W-1:0] CFG_WORD_LAST    = 15'h0008;

   // Bus encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ    = 2'h3;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;
   localparam logic       HRESP_OKAY    = 1'b0;

endpackage

// [rtl/nvm_field.sv]
`timescale 1ns/1ps
module nvm_field #(
   parameter int               WIDTH     = 8,
   parameter bit               HAS_RESET = 1'b1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             wr_en,
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic             ld_en,
   input  wire logic [WIDTH-1:0] ld_data,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] next_q;

   // Hardware load has priority; the bus cannot write in the same cycle
   always_comb begin
      next_q = q;
      if (ld_en) begin
         next_q = ld_data;
      end else if (wr_en) begin
         next_q = wr_data;
      end
   end

   generate
      if (HAS_RESET) begin : g_rst
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               q <= RESET_VAL;
            end else begin
               q <= next_q;
            end
         end
      end else begin : g_keep
         // Contents survive reset; unknown only at power-up
         always_ff @(posedge hclk) begin
            q <= next_q;
         end
      end
   endgenerate
endmodule

// [rtl/nvm_data_address_regs.sv]
`timescale 1ns/1ps
// Behaviour
// - Low data byte is read/write storage
// - High data bits 5-0 hold word 13:8
// - High data bits 7-6 read zero
// - Data registers keep contents across resets
// - Low address byte read/write, resets zero
// - High address bits 6-0, reset zero
// - High address bit 7 reads one
// - Bad configuration read clears data registers
module nvm_data_address_regs
   import nvm_regs_pkg::*;
(
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic              hready,
   input  wire logic [31:0]       hwdata,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic                   mem_read,
   output logic      [ADDR_W-1:0] mem_address,
   output logic                   mem_program_space,
   output logic                   mem_config_space,
   output logic                   mem_latch_only,
   input  wire logic [WORD_W-1:0] mem_read_word
);

   logic                   wr_pend;
   logic [7:0]             wr_addr;
   logic                   next_wr_pend;
   logic [7:0]             next_wr_addr;
   logic [31:0]            next_hrdata;
   logic                   bus_take;

   logic [7:0]             control;
   logic [7:0]             next_control;
   logic                   next_mem_read;
   logic                   read_done;
   logic                   cfg_readable;
   logic [WORD_W-1:0]      load_word;

   logic [DATA_LOW_W-1:0]  data_low;
   logic [DATA_HIGH_W-1:0] data_high;
   logic [ADDR_LOW_W-1:0]  addr_low;
   logic [ADDR_HIGH_W-1:0] addr_high;
   logic [ADDR_LOW_W-1:0]  next_addr_low;
   logic [ADDR_HIGH_W-1:0] next_addr_high;

   logic                   wr_data_low;
   logic                   wr_data_high;
   logic                   wr_addr_low;
   logic                   wr_addr_high;
   logic                   wr_control;

   // Address phase: word transfers only, other sizes are ignored
   assign bus_take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ)
                     && (hsize == HSIZE_WORD);

   always_comb begin
      next_wr_pend = bus_take && hwrite;
      next_wr_addr = wr_addr;
      if (bus_take && hwrite) begin
         next_wr_addr = haddr[7:0];
      end
   end

   // Write decode in the data phase
   always_comb begin
      wr_data_low  = 1'b0;
      wr_data_high = 1'b0;
      wr_addr_low  = 1'b0;
      wr_addr_high = 1'b0;
      wr_control   = 1'b0;
      if (!wr_pend) begin
         wr_data_low = 1'b0;
      end else if (wr_addr == OFS_DATA_LOW) begin
         wr_data_low = 1'b1;
      end else if (wr_addr == OFS_DATA_HIGH) begin
         wr_data_high = 1'b1;
      end else if (wr_addr == OFS_ADDRESS_LOW) begin
         wr_addr_low = 1'b1;
      end else if (wr_addr == OFS_ADDRESS_HIGH) begin
         wr_addr_high = 1'b1;
      end else if (wr_addr == OFS_CONTROL_ONE) begin
         wr_control = 1'b1;
      end
   end

   // Read mux, registered so data stands through the data phase
   always_comb begin
      next_hrdata = hrdata;
      if (bus_take && !hwrite) begin
         if (haddr[7:0] == OFS_DATA_LOW) begin
            next_hrdata = {24'h00_0000, data_low};
         end else if (haddr[7:0] == OFS_DATA_HIGH) begin
            next_hrdata = {24'h00_0000, DATA_HIGH_PAD, data_high};
         end else if (haddr[7:0] == OFS_ADDRESS_LOW) begin
            next_hrdata = {24'h00_0000, addr_low};
         end else if (haddr[7:0] == OFS_ADDRESS_HIGH) begin
            next_hrdata = {24'h00_0000, ADDR_HIGH_PAD, addr_high};
         end else if (haddr[7:0] == OFS_CONTROL_ONE) begin
            next_hrdata = {24'h00_0000, control};
         end else begin
            // Unlock port is write-only; unmapped reads give zero
            next_hrdata = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend   <= 1'b0;
         wr_addr   <= 8'h00;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b0;
         hresp     <= HRESP_OKAY;
      end else begin
         wr_pend   <= next_wr_pend;
         wr_addr   <= next_wr_addr;
         hrdata    <= next_hrdata;
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
      end
   end

   // Configuration space: only user IDs, device ID and config words read back
   always_comb begin
      cfg_readable = (mem_address <= CFG_USER_ID_LAST) || (mem_address == CFG_DEVICE_ID)
                     || (mem_address >= CFG_WORD_FIRST && mem_address <= CFG_WORD_LAST);
      load_word = mem_read_word;
      if (control[BIT_CONFIG_SPACE] && !cfg_readable) begin
         load_word = {WORD_W{1'b0}};
      end
   end

   // The array answers in the same cycle as the mem_read strobe
   assign read_done = mem_read;

   // Control register; the write strobe is held at zero and the error flag is stored as software writes it
   always_comb begin
      next_control  = control;
      next_mem_read = 1'b0;
      if (wr_control) begin
         next_control[BIT_PROGRAM_SPACE] = hwdata[BIT_PROGRAM_SPACE];
         next_control[BIT_CONFIG_SPACE]  = hwdata[BIT_CONFIG_SPACE];
         next_control[BIT_LATCH_ONLY]    = hwdata[BIT_LATCH_ONLY];
         next_control[BIT_ERASE_SELECT]  = hwdata[BIT_ERASE_SELECT];
         next_control[BIT_WRITE_ERROR]   = hwdata[BIT_WRITE_ERROR];
         next_control[BIT_WRITE_ENABLE]  = hwdata[BIT_WRITE_ENABLE];
         // Strobe can only be set by software
         if (hwdata[BIT_READ_STROBE] && !control[BIT_READ_STROBE]) begin
            next_control[BIT_READ_STROBE] = 1'b1;
            next_mem_read                 = 1'b1;
         end
      end
      if (read_done) begin
         next_control[BIT_READ_STROBE] = 1'b0;
      end
      next_control[BIT_WRITE_STROBE] = 1'b0;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         control           <= RST_CONTROL_ONE;
         mem_read          <= 1'b0;
         mem_program_space <= 1'b0;
         mem_config_space  <= 1'b0;
         mem_latch_only    <= 1'b0;
         mem_address       <= {ADDR_W{1'b0}};
      end else begin
         control           <= next_control;
         mem_read          <= next_mem_read;
         mem_program_space <= next_control[BIT_PROGRAM_SPACE];
         mem_config_space  <= next_control[BIT_CONFIG_SPACE];
         mem_latch_only    <= next_control[BIT_LATCH_ONLY];
         mem_address       <= {next_addr_high, next_addr_low};
      end
   end

   // Next address copies so the address port is a plain flop
   always_comb begin
      next_addr_low  = wr_addr_low ? hwdata[ADDR_LOW_W-1:0] : addr_low;
      next_addr_high = wr_addr_high ? hwdata[ADDR_HIGH_W-1:0] : addr_high;
   end

   // are software duties; the unlock port accepts and drops writes

   nvm_field #(.WIDTH(DATA_LOW_W), .HAS_RESET(1'b0), .RESET_VAL(8'h00)) u_data_low (
      .hclk    (hclk),
      .hresetn (hresetn),
      .wr_en   (wr_data_low),
      .wr_data (hwdata[DATA_LOW_W-1:0]),
      .ld_en   (read_done),
      .ld_data (load_word[DATA_LOW_W-1:0]),
      .q       (data_low)
   );

   nvm_field #(.WIDTH(DATA_HIGH_W), .HAS_RESET(1'b0), .RESET_VAL(6'h00)) u_data_high (
      .hclk    (hclk),
      .hresetn (hresetn),
      .wr_en   (wr_data_high),
      .wr_data (hwdata[DATA_HIGH_W-1:0]),
      .ld_en   (read_done),
      .ld_data (load_word[WORD_W-1:DATA_LOW_W]),
      .q       (data_high)
   );

   nvm_field #(.WIDTH(ADDR_LOW_W), .HAS_RESET(1'b1), .RESET_VAL(RST_ADDRESS_LOW)) u_addr_low (
      .hclk    (hclk),
      .hresetn (hresetn),
      .wr_en   (wr_addr_low),
      .wr_data (hwdata[ADDR_LOW_W-1:0]),
      .ld_en   (1'b0),
      .ld_data (RST_ADDRESS_LOW),
      .q       (addr_low)
   );

   nvm_field #(.WIDTH(ADDR_HIGH_W), .HAS_RESET(1'b1), .RESET_VAL(RST_ADDRESS_HIGH)) u_addr_high (
      .hclk    (hclk),
      .hresetn (hresetn),
      .wr_en   (wr_addr_high),
      .wr_data (hwdata[ADDR_HIGH_W-1:0]),
      .ld_en   (1'b0),
      .ld_data (RST_ADDRESS_HIGH),
      .q       (addr_high)
   );

endmodule

// [dv/nvm_data_address_regs_assertions.sv]
`timescale 1ns/1ps
module nvm_data_address_regs_assertions
   import nvm_regs_pkg::*;
(
   input wire logic              hclk,
   input wire logic              hresetn,
   input wire logic              hsel,
   input wire logic [31:0]       haddr,
   input wire logic [1:0]        htrans,
   input wire logic              hwrite,
   input wire logic [2:0]        hsize,
   input wire logic              hready,
   input wire logic [31:0]       hwdata,
   input wire logic [31:0]       hrdata,
   input wire logic              hreadyout,
   input wire logic              hresp,
   input wire logic              mem_read,
   input wire logic [ADDR_W-1:0] mem_address,
   input wire logic              mem_program_space,
   input wire logic              mem_config_space,
   input wire logic              mem_latch_only
);
   logic       ph;
   logic       pw;
   logic [7:0] pa;
   // Data phase flags, so hwdata and hrdata are judged in their own cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph <= 1'b0;
         pw <= 1'b0;
         pa <= 8'h00;
      end else begin
         ph <= hsel && hready && htrans[1] && hsize == HSIZE_WORD;
         pw <= hwrite;
         pa <= haddr[7:0];
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_resp_okay: assert property (hresp == HRESP_OKAY) else $error("hresp not okay");
   a_ready_up: assert property ($past(hresetn) |-> hreadyout) else $error("hreadyout low");
   a_strobe_pulse: assert property (mem_read |=> !mem_read) else $error("mem_read too long");
   a_strobe_cause: assert property ($rose(mem_read) |->
      $past(ph && pw && pa == OFS_CONTROL_ONE && hwdata[0])) else $error("mem_read uncaused");
   a_strobe_start: assert property (ph && pw && pa == OFS_CONTROL_ONE && hwdata[0] && !mem_read
      |=> mem_read) else $error("mem_read missing");
   a_addr_low: assert property (ph && pw && pa == OFS_ADDRESS_LOW
      |=> mem_address[7:0] == $past(hwdata[7:0])) else $error("address low wrong");
   a_addr_high: assert property (ph && pw && pa == OFS_ADDRESS_HIGH
      |=> mem_address[14:8] == $past(hwdata[6:0])) else $error("address high wrong");
   a_addr_hold: assert property (!(ph && pw && (pa == OFS_ADDRESS_LOW || pa == OFS_ADDRESS_HIGH))
      |=> $stable(mem_address)) else $error("address moved");
   a_space_bits: assert property (ph && pw && pa == OFS_CONTROL_ONE |=>
      {mem_program_space, mem_config_space, mem_latch_only} == $past(hwdata[7:5])) else $error("space bits");
   a_high_pad: assert property (ph && !pw && pa == OFS_ADDRESS_HIGH
      |-> hrdata[31:7] == 25'h1) else $error("address pad wrong");
   a_data_pad: assert property (ph && !pw && pa == OFS_DATA_HIGH
      |-> hrdata[31:6] == 26'h0) else $error("data pad wrong");
endmodule

// [dv/nvm_data_address_regs_bench.sv]
`timescale 1ns/1ps
module nvm_data_address_regs_bench;
   import nvm_regs_pkg::*;
   logic              hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0]        htrans = 2'h0;
   logic [2:0]        hsize = HSIZE_WORD;
   logic [31:0]       haddr = 32'h0, hwdata = 32'h0, hrdata, rs = 32'hefef_9cdf, v, r;
   logic [WORD_W-1:0] mem_read_word = '0;
   logic [ADDR_W-1:0] mem_address;
   logic              hready, hreadyout, hresp, mem_read;
   logic              mem_program_space, mem_config_space, mem_latch_only, bad;
   logic [7:0]        dl, dh, al, ah, ctl;
   int                err_count = 0;
   int                n_tests = 0;
   assign hready = hreadyout;
   nvm_data_address_regs dut (
      .hclk              (hclk),
      .hresetn           (hresetn),
      .hsel              (hsel),
      .haddr             (haddr),
      .htrans            (htrans),
      .hwrite            (hwrite),
      .hsize             (hsize),
      .hready            (hready),
      .hwdata            (hwdata),
      .hrdata            (hrdata),
      .hreadyout         (hreadyout),
      .hresp             (hresp),
      .mem_read          (mem_read),
      .mem_address       (mem_address),
      .mem_program_space (mem_program_space),
      .mem_config_space  (mem_config_space),
      .mem_latch_only    (mem_latch_only),
      .mem_read_word     (mem_read_word)
   );
   initial begin
      forever #20 hclk = ~hclk;
   end
   function automatic logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Waits on hready rather than counting cycles; the watchdog ends a hang
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(r, exp);
   endtask
   task automatic rst();
      hresetn <= 1'b0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      rst();
      rd(OFS_ADDRESS_LOW, 32'h0);
      rd(OFS_ADDRESS_HIGH, 32'h80);
      rd(OFS_CONTROL_ONE, 32'h0);
      $display("test reset values done");
      repeat (4) begin
         v = rnd();
         dl = v[7:0];
         dh = {2'b00, v[13:8]};
         wr(OFS_DATA_LOW, v);
         wr(OFS_DATA_HIGH, v >> 8);
         rd(OFS_DATA_LOW, dl);
         rd(OFS_DATA_HIGH, dh);
         v = rnd();
         al = v[7:0];
         ah = {1'b1, v[14:8]};
         wr(OFS_ADDRESS_LOW, v);
         wr(OFS_ADDRESS_HIGH, v >> 8);
         rd(OFS_ADDRESS_LOW, al);
         rd(OFS_ADDRESS_HIGH, ah);
         chk(mem_address, {ah[6:0], al});
      end
      $display("test register storage done");
      wr(OFS_ADDRESS_HIGH, 32'h0);
      // Config words 0..9 cover both edges of each readable range
      for (int i = 0; i < 12; i++) begin
         ctl = (i < 10) ? 8'h41 : ((i == 10) ? 8'h01 : 8'ha1);
         v = rnd();
         al = (i < 10) ? 8'(i) : v[23:16];
         bad = ctl[6] && !(al <= 3 || al == 6 || al == 7 || al == 8);
         mem_read_word <= v[WORD_W-1:0];
         wr(OFS_ADDRESS_LOW, al);
         wr(OFS_CONTROL_ONE, ctl);
         dl = bad ? 8'h00 : v[7:0];
         dh = bad ? 8'h00 : {2'b00, v[13:8]};
         rd(OFS_CONTROL_ONE, ctl & 8'hfe);
         chk({mem_program_space, mem_config_space, mem_latch_only}, ctl[7:5]);
         rd(OFS_DATA_LOW, dl);
         rd(OFS_DATA_HIGH, dh);
      end
      $display("test read strobe done");
      rst();
      rd(OFS_DATA_LOW, dl);
      rd(OFS_DATA_HIGH, dh);
      rd(OFS_ADDRESS_LOW, 32'h0);
      rd(OFS_ADDRESS_HIGH, 32'h80);
      $display("test second reset done");
      wr(OFS_UNLOCK_PORT, 32'h55);
      wr(OFS_UNLOCK_PORT, 32'haa);
      rd(OFS_UNLOCK_PORT, 32'h0);
      rd(8'h18, 32'h0);
      $display("test unlock and unmapped done");
      conclude();
   end
   initial begin
      #400us;
      err_count++;
      conclude();
   end
endmodule
bind nvm_data_address_regs nvm_data_address_regs_assertions chk_i (
   .hclk              (hclk),
   .hresetn           (hresetn),
   .hsel              (hsel),
   .haddr             (haddr),
   .htrans            (htrans),
   .hwrite            (hwrite),
   .hsize             (hsize),
   .hready            (hready),
   .hwdata            (hwdata),
   .hrdata            (hrdata),
   .hreadyout         (hreadyout),
   .hresp             (hresp),
   .mem_read          (mem_read),
   .mem_address       (mem_address),
   .mem_program_space (mem_program_space),
   .mem_config_space  (mem_config_space),
   .mem_latch_only    (mem_latch_only)
);
